/* design/fdl_dec_if.sv */
// character to segment lookup carrier
`timescale 1ns/10ps
interface fdl_dec_if;
  logic [3:0]          char_code;
  fdl_pkg::fdl_seg_type segs;
  modport client (output char_code, input segs);
  modport server (input char_code, output segs);
endinterface

/* design/fdl_decoder.sv */
// seven segment character decoder, hex or alternate letter set
`timescale 1ns/10ps
`include "fdl_map.svh"
module fdl_decoder #(
  parameter fdl_pkg::fdl_decode_type DECODE = fdl_pkg::fdl_dec_hex
) (
  fdl_dec_if.server dec
);
  import fdl_pkg::*;
  // bit order g f e d c b a
  always_comb
  begin
    case (dec.char_code)
      4'h0: dec.segs = 7'h3f;
      4'h1: dec.segs = 7'h06;
      4'h2: dec.segs = 7'h5b;
      4'h3: dec.segs = 7'h4f;
      4'h4: dec.segs = 7'h66;
      4'h5: dec.segs = 7'h6d;
      4'h6: dec.segs = 7'h7d;
      4'h7: dec.segs = 7'h07;
      4'h8: dec.segs = 7'h7f;
      4'h9: dec.segs = 7'h6f;
      default:
      begin
        if (DECODE == fdl_dec_hex)
        begin
          case (dec.char_code)
            4'ha: dec.segs = 7'h77;
            4'hb: dec.segs = 7'h7c;
            4'hc: dec.segs = 7'h39;
            4'hd: dec.segs = 7'h5e;
            4'he: dec.segs = 7'h79;
            default: dec.segs = 7'h71;
          endcase
        end
        else
        begin
          case (dec.char_code)
            4'ha: dec.segs = `FDL_CODE_DASH;
            4'hb: dec.segs = `FDL_CODE_E;
            4'hc: dec.segs = `FDL_CODE_H;
            4'hd: dec.segs = `FDL_CODE_L;
            4'he: dec.segs = `FDL_CODE_P;
            default: dec.segs = `FDL_CODE_BLANK;
          endcase
        end
      end
    endcase
  end
endmodule

/* design/fdl_driver.sv */
// four digit seven segment lcd decoder and static driver
//
// Behaviour
// - multiplexed input: four data bits plus four one-hot digit strobes
// - processor input: data and two-bit digit code held in input latches
// - hex option decodes all sixteen values to hex characters
// - alternate option: 0-9, then dash, E, H, L, P, blank
// - values zero to nine show decimal digits on both options
// - 28 segment outputs plus backplane from own oscillator and divider
// - segments static, each digit holds pattern until rewritten
// - oscillator tied low: backplane pin becomes input, segments follow it
// - free-running backplane is oscillator divided by 128
// - both selects low load latches; rising select stores decoded digit
// - digit code 00 is digit four, 11 is digit one
// - alternate codes 1010 to 1111 map to dash, E, H, L, P, blank
`timescale 1ns/10ps
`include "fdl_map.svh"
module fdl_driver #(
  parameter fdl_pkg::fdl_input_type  INPUT  = fdl_pkg::fdl_in_mux,
  parameter fdl_pkg::fdl_decode_type DECODE = fdl_pkg::fdl_dec_hex,
  parameter int OSC_DIV = `FDL_OSC_DIV_DEF
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        char_bit_low,
  input  wire logic        char_bit_1,
  input  wire logic        char_bit_2,
  input  wire logic        char_bit_high,
  input  wire logic        digit_strobe_one,
  input  wire logic        digit_strobe_two,
  input  wire logic        digit_strobe_three,
  input  wire logic        digit_strobe_four,
  input  wire logic        digit_code_low,
  input  wire logic        digit_code_high,
  input  wire logic        chip_sel_a_n,
  input  wire logic        chip_sel_b_n,
  input  wire logic        osc_grounded,
  input  wire logic        backplane_pin_in,
  output logic             backplane_pin_out,
  output logic             backplane_pin_oe,
  output logic [27:0]      segments
);
  import fdl_pkg::*;

  localparam int FILT = `FDL_SLAVE_FILT_CYC;

  // osc_cnt is 16 bits wide, slave_cnt 8 bits wide
  if (OSC_DIV < 1 || OSC_DIV > 65535 || FILT > 255)
  begin
    $error("OSC_DIV or slave filter count out of range");
  end

  typedef struct packed {
    logic [15:0] osc_cnt;
    logic [6:0]  bp_div;
    logic [7:0]  slave_cnt;
    logic        slave;
    logic [3:0]  in_data;
    logic [1:0]  in_code;
    logic        cs_both;
    logic [27:0] digits;
    logic [27:0] seg_out;
    logic        bp_out;
  } fdl_state_type;

  fdl_state_type st;
  fdl_state_type next_st;

  fdl_dec_if dec ();
  fdl_decoder #(.DECODE(DECODE)) u_dec (.dec(dec.server));

  logic [3:0] char_in;
  logic [3:0] strobes;
  logic       bp_level;
  logic       cs_low;
  logic [1:0] digit_idx;
  logic       do_write;

  assign char_in = {char_bit_high, char_bit_2, char_bit_1, char_bit_low};
  assign strobes = {digit_strobe_four, digit_strobe_three,
                    digit_strobe_two, digit_strobe_one};
  assign cs_low  = !chip_sel_a_n && !chip_sel_b_n;
  assign dec.char_code = (INPUT == fdl_in_cpu) ? st.in_data : char_in;
  assign bp_level = st.slave ? backplane_pin_in : st.bp_div[6];

  always_comb
  begin
    next_st = st;
    do_write = 1'b0;
    digit_idx = 2'h0;
    // oscillator stand-in: one tick every OSC_DIV clocks
    if (st.osc_cnt == 16'(OSC_DIV - 1))
    begin
      next_st.osc_cnt = 16'h0000;
      next_st.bp_div = st.bp_div + 7'h01;
    end
    else
      next_st.osc_cnt = st.osc_cnt + 16'h0001;
    // grounded oscillator must persist to count as slave request
    if (osc_grounded)
    begin
      if (st.slave_cnt != 8'(FILT))
        next_st.slave_cnt = st.slave_cnt + 8'h01;
      else
        next_st.slave = 1'b1;
    end
    else
    begin
      next_st.slave_cnt = 8'h00;
      next_st.slave = 1'b0;
    end
    if (INPUT == fdl_in_cpu)
    begin
      next_st.cs_both = cs_low;
      if (cs_low)
      begin
        next_st.in_data = char_in;
        next_st.in_code = {digit_code_high, digit_code_low};
      end
      if (st.cs_both && !cs_low)
      begin
        do_write = 1'b1;
        digit_idx = ~st.in_code;
      end
    end
    else
    begin
      for (int i = 0; i < `FDL_DIGITS; i++)
      begin
        if (strobes[i])
        begin
          do_write = 1'b1;
          digit_idx = 2'(i);
        end
      end
    end
    if (do_write)
      next_st.digits[digit_idx*`FDL_SEGS +: `FDL_SEGS] = dec.segs;
    next_st.bp_out = bp_level;
    next_st.seg_out = st.digits ^ {28{bp_level}};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign backplane_pin_out = st.bp_out;
  assign backplane_pin_oe  = !st.slave;
  assign segments          = st.seg_out;

  chk_seg_phase: assert property (@(posedge clk)
    disable iff (!rst_n)
    segments == ($past(st.digits) ^ {28{$past(bp_level)}}))
    else $error("segment phase wrong");

  chk_slave_oe: assert property (@(posedge clk)
    disable iff (!rst_n)
    osc_grounded [*8] |-> ##[0:130] (!backplane_pin_oe || !osc_grounded))
    else $error("backplane not released");

  chk_slave_filter: assert property (@(posedge clk)
    disable iff (!rst_n)
    $rose(osc_grounded) |=> backplane_pin_oe [*8])
    else $error("short grounding released backplane");

  chk_master_oe: assert property (@(posedge clk)
    disable iff (!rst_n)
    !osc_grounded |=> backplane_pin_oe)
    else $error("backplane driver off");

  chk_bp_div: assert property (@(posedge clk)
    disable iff (!rst_n)
    (st.osc_cnt == 16'(OSC_DIV - 1)) |=>
      st.bp_div == $past(st.bp_div) + 7'h01)
    else $error("backplane divider stuck");

  chk_hold_digits: assert property (@(posedge clk)
    disable iff (!rst_n)
    !do_write |=> $stable(st.digits))
    else $error("digit changed without write");

  chk_write_digit: assert property (@(posedge clk)
    disable iff (!rst_n)
    do_write |=> st.digits[$past(digit_idx)*7 +: 7] == $past(dec.segs))
    else $error("digit not stored");

  chk_mux_one: assert property (@(posedge clk)
    disable iff (!rst_n)
    (INPUT == fdl_in_mux && strobes == 4'h1) |=>
      st.digits[27:7] == $past(st.digits[27:7]))
    else $error("strobe one touched other digits");

  chk_cpu_latch: assert property (@(posedge clk)
    disable iff (!rst_n)
    (INPUT == fdl_in_cpu && cs_low) |=> st.in_data == $past(char_in))
    else $error("input latch missed");

  chk_code_one: assert property (@(posedge clk)
    disable iff (!rst_n)
    (INPUT == fdl_in_cpu && do_write && st.in_code == 2'h3) |=>
      st.digits[6:0] == $past(dec.segs))
    else $error("code 11 missed digit one");

  chk_code_four: assert property (@(posedge clk)
    disable iff (!rst_n)
    (INPUT == fdl_in_cpu && do_write && st.in_code == 2'h0) |=>
      st.digits[27:21] == $past(dec.segs))
    else $error("code 00 missed digit four");

  chk_decimal: assert property (@(posedge clk)
    disable iff (!rst_n)
    (dec.char_code == 4'h0) |-> dec.segs == 7'h3f)
    else $error("zero decoded wrong");
endmodule

/* design/fdl_map.svh */
// offsets, codes and timing counts for the lcd decoder driver
`ifndef FDL_MAP_SVH
`define FDL_MAP_SVH
`define FDL_BP_DIV        128
`define FDL_DIGITS        4
`define FDL_SEGS          7
`define FDL_CLK_NS        8
`define FDL_OSC_DIV_DEF   977
`define FDL_SLAVE_FILT_NS 1000
`define FDL_SLAVE_FILT_CYC ((`FDL_SLAVE_FILT_NS + `FDL_CLK_NS - 1) / `FDL_CLK_NS)
`define FDL_CODE_DASH     7'h40
`define FDL_CODE_E        7'h79
`define FDL_CODE_H        7'h76
`define FDL_CODE_L        7'h38
`define FDL_CODE_P        7'h73
`define FDL_CODE_BLANK    7'h00
`endif

/* design/fdl_pkg.sv */
// types for the lcd decoder driver
package fdl_pkg;
  typedef enum logic {fdl_in_mux, fdl_in_cpu} fdl_input_type;
  typedef enum logic {fdl_dec_hex, fdl_dec_alt} fdl_decode_type;
  typedef logic [6:0] fdl_seg_type;
endpackage

/* tb/fdl_driver_tb.sv */
// self-checking bench for the lcd driver, processor and strobe variants
`timescale 1ns/10ps
`include "fdl_map.svh"
module fdl_driver_tb;
  import fdl_pkg::*;
  localparam int DIV = 2;
  localparam logic [6:0] DEC [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
    7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
  localparam logic [6:0] HEX [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
    7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e,
    7'h79, 7'h71};
  logic        clk;
  logic        rst_n;
  logic        osc_grounded;
  logic        ext_bp;
  logic        bp_wire;
  logic        a_n;
  logic        b_n;
  logic [1:0]  code;
  logic [3:0]  data;
  logic        bp_out;
  logic        bp_oe;
  logic [27:0] segments;
  logic [6:0]  exp_digit [4];
  logic [3:0]  strobes;
  logic        hx_bp_out;
  logic        hx_bp_oe;
  logic [27:0] hx_segments;
  logic [6:0]  hx_exp [4];
  int          fail_count;
  int          checked;

  assign bp_wire = bp_oe ? bp_out : ext_bp;
  always #4 clk = ~clk;

  fdl_host u_host (.clk(clk), .sel_a_n(a_n), .sel_b_n(b_n), .code(code),
    .strobes(strobes), .data(data));
  fdl_driver #(.INPUT(fdl_in_cpu), .DECODE(fdl_dec_alt), .OSC_DIV(DIV))
  u_dut (
    .clk(clk), .rst_n(rst_n),
    .char_bit_low(data[0]), .char_bit_1(data[1]),
    .char_bit_2(data[2]), .char_bit_high(data[3]),
    .digit_strobe_one(1'b0), .digit_strobe_two(1'b0),
    .digit_strobe_three(1'b0), .digit_strobe_four(1'b0),
    .digit_code_low(code[0]), .digit_code_high(code[1]),
    .chip_sel_a_n(a_n), .chip_sel_b_n(b_n),
    .osc_grounded(osc_grounded), .backplane_pin_in(bp_wire),
    .backplane_pin_out(bp_out), .backplane_pin_oe(bp_oe),
    .segments(segments)
  );
  fdl_driver #(.INPUT(fdl_in_mux), .DECODE(fdl_dec_hex), .OSC_DIV(DIV))
  u_dut_hex (
    .clk(clk), .rst_n(rst_n),
    .char_bit_low(data[0]), .char_bit_1(data[1]),
    .char_bit_2(data[2]), .char_bit_high(data[3]),
    .digit_strobe_one(strobes[0]), .digit_strobe_two(strobes[1]),
    .digit_strobe_three(strobes[2]), .digit_strobe_four(strobes[3]),
    .digit_code_low(code[0]), .digit_code_high(code[1]),
    .chip_sel_a_n(a_n), .chip_sel_b_n(b_n),
    .osc_grounded(osc_grounded), .backplane_pin_in(bp_wire),
    .backplane_pin_out(hx_bp_out), .backplane_pin_oe(hx_bp_oe),
    .segments(hx_segments)
  );

  function automatic logic [6:0] alt_pat(input logic [3:0] v);
    case (v)
      4'ha: alt_pat = `FDL_CODE_DASH;
      4'hb: alt_pat = `FDL_CODE_E;
      4'hc: alt_pat = `FDL_CODE_H;
      4'hd: alt_pat = `FDL_CODE_L;
      4'he: alt_pat = `FDL_CODE_P;
      4'hf: alt_pat = `FDL_CODE_BLANK;
      default: alt_pat = DEC[v];
    endcase
  endfunction

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // waits for a backplane edge, returns cycles taken
  task automatic wait_toggle(output int n);
    logic b;
    b = bp_out;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (bp_out === b && n < 1000);
    if (n >= 1000)
    begin
      fail_count++;
      finish_test();
    end
  endtask

  task automatic check_all;
    logic b;
    int   n;
    n = 0;
    @(negedge clk);
    // avoid sampling right at a backplane edge
    do
    begin
      b = bp_out;
      @(negedge clk);
      n++;
    end
    while (bp_out !== b && n < 1000);
    if (n >= 1000)
    begin
      fail_count++;
      finish_test();
    end
    for (int d = 0; d < 4; d++)
    begin
      check(segments[d*7 +: 7], exp_digit[d] ^ {7{bp_out}});
      check(hx_segments[d*7 +: 7], hx_exp[d] ^ {7{hx_bp_out}});
    end
  endtask

  task automatic test_codes;
    for (int v = 0; v < 16; v++)
    begin
      u_host.write(2'(v), 4'(v));
      exp_digit[3 - (v % 4)] = alt_pat(4'(v));
      check_all();
    end
    $display("test codes done");
  endtask

  task automatic test_mux;
    for (int v = 0; v < 16; v++)
    begin
      u_host.strobe(2'(v), 4'(v));
      hx_exp[v % 4] = HEX[v];
      check_all();
    end
    $display("test mux done");
  endtask

  task automatic test_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    check(segments, 28'h0);
    check(hx_segments, 28'h0);
    check(bp_oe, 1'b1);
    check(bp_out, 1'b0);
    @(posedge clk);
    rst_n <= 1'b1;
    for (int d = 0; d < 4; d++)
    begin
      exp_digit[d] = 7'h00;
      hx_exp[d] = 7'h00;
    end
    check_all();
    $display("test reset done");
  endtask

  task automatic test_backplane;
    int n;
    check(bp_oe, 1'b1);
    check(hx_bp_oe, 1'b1);
    wait_toggle(n);
    wait_toggle(n);
    check(n, 64 * DIV);
    $display("test backplane done");
  endtask

  task automatic test_slave;
    logic [27:0] all;
    logic [27:0] hx_all;
    all = {exp_digit[3], exp_digit[2], exp_digit[1], exp_digit[0]};
    hx_all = {hx_exp[3], hx_exp[2], hx_exp[1], hx_exp[0]};
    @(posedge clk);
    osc_grounded <= 1'b1;
    repeat (130) @(posedge clk);
    for (int k = 0; k < 4; k++)
    begin
      // no faster than the scaled free-running backplane
      ext_bp <= ~k[0];
      repeat (3) @(posedge clk);
      @(negedge clk);
      check(bp_oe, 1'b0);
      check(hx_bp_oe, 1'b0);
      check(bp_out, {~k[0]});
      check(segments, all ^ {28{~k[0]}});
      check(hx_segments, hx_all ^ {28{~k[0]}});
      repeat (64 * DIV - 3) @(posedge clk);
    end
    osc_grounded <= 1'b0;
    $display("test slave done");
  endtask

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    osc_grounded = 1'b0;
    ext_bp = 1'b0;
    fail_count = 0;
    checked = 0;
    for (int d = 0; d < 4; d++)
    begin
      exp_digit[d] = 7'h00;
      hx_exp[d] = 7'h00;
    end
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    check_all();
    test_backplane();
    test_codes();
    test_mux();
    test_slave();
    test_reset();
    finish_test();
  end
endmodule

/* tb/fdl_host.sv */
// processor-side and strobe host model writing characters with digit codes or digit strobes
`timescale 1ns/10ps
module fdl_host (
  input  wire logic       clk,
  output logic            sel_a_n,
  output logic            sel_b_n,
  output logic [1:0]      code,
  output logic [3:0]      strobes,
  output logic [3:0]      data
);
  initial
  begin
    sel_a_n = 1'b1;
    sel_b_n = 1'b1;
    code    = 2'h0;
    data    = 4'h0;
    strobes = 4'h0;
  end
  task automatic strobe(input logic [1:0] d, input logic [3:0] v);
    @(posedge clk);
    strobes <= 4'h1 << d;
    data    <= v;
    repeat (125) @(posedge clk);
    strobes <= 4'h0;
    repeat (25) @(posedge clk);
    // hold time over, lines no longer hold the character
    data <= ~v;
    repeat (225) @(posedge clk);
  endtask
  task automatic write(input logic [1:0] c, input logic [3:0] v);
    @(posedge clk);
    sel_a_n <= 1'b0;
    sel_b_n <= 1'b0;
    code    <= c;
    data    <= v;
    repeat (25) @(posedge clk);
    sel_a_n <= 1'b1;
    sel_b_n <= 1'b1;
    @(posedge clk);
    // bus released, lines no longer hold the character
    code <= ~c;
    data <= ~v;
    repeat (250) @(posedge clk);
  endtask
endmodule
